// ---- relay_output_conditioner.sv ----
// Function
// - Each relay has force select: normal, forced energized, forced de-energized.
// - A new coil state is kept at least the hold time, 0 to 300 s, unless forced.
// - Latch option, default on, keeps a picked-up relay picked up.
// - Per-relay acknowledge input clears only that relay's latch.
// - Per-relay acknowledge is ignored while latching is disabled.
// - Group force setting, when not normal, overrides per-relay force.
// - Acknowledge works only after drive is gone and hold expired.
// - Common acknowledge, external or remote, clears all relays at once.
//
// Purpose: Conditions drive of five output relays, AXI4-Lite settings
// Assumes: Drive and ack pins are asynchronous; 200 MHz clock
// Notes:   Times in 10 ms units; writes above 30000 saturate
`timescale 1ns/1ps
module relay_output_conditioner
  import relay_cond_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [NUM_RELAYS-1:0] relay_drive,
  input  wire logic [NUM_RELAYS-1:0] relay_ack,
  input  wire logic                  ext_ack,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [NUM_RELAYS-1:0]      relay_coil
);
  import relay_cond_pkg::*;

  logic                    rst_meta;
  logic                    rst_n;
  logic [NUM_RELAYS:0]     pins_sync;
  logic [NUM_RELAYS-1:0]   drive_s;
  logic [NUM_RELAYS-1:0]   ack_s;
  logic                    ext_ack_s;
  logic [NUM_RELAYS-1:0]   ack_eff;
  logic [NUM_RELAYS-1:0]   coil_int;
  logic [NUM_RELAYS-1:0]   active;
  logic [NUM_RELAYS-1:0]   latched;
  force_t                  force_sel [NUM_RELAYS];
  force_t                  force_eff [NUM_RELAYS];
  force_t                  group_force;
  logic [NUM_RELAYS-1:0]   latch_en;
  logic [NUM_RELAYS-1:0]   closed_circuit;
  logic [TIME_W-1:0]       hold_time [NUM_RELAYS];
  logic [TIME_W-1:0]       off_delay [NUM_RELAYS];
  logic                    remote_ack;
  logic [31:0]             tick_cnt;
  logic                    tick;
  logic                    aw_held;
  logic                    w_held;
  logic [7:0]              aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    wr_go;
  logic                    wr_hit;

  // Two-stage reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  relay_sync #(.WIDTH(NUM_RELAYS + 1)) u_sync_drive (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({ext_ack, relay_drive}),
    .dout  (pins_sync)
  );
  relay_sync #(.WIDTH(NUM_RELAYS)) u_sync_ack (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (relay_ack),
    .dout  (ack_s)
  );
  assign drive_s   = pins_sync[NUM_RELAYS-1:0];
  assign ext_ack_s = pins_sync[NUM_RELAYS];

  // 10 ms time base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_DIV - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'd1;
      tick     <= 1'b0;
    end
  end

  // Common ack reaches every relay
  assign ack_eff = ack_s | {NUM_RELAYS{ext_ack_s | remote_ack}};

  function automatic force_t merge_force(input force_t grp, input force_t own);
    merge_force = (grp != FORCE_NORMAL) ? grp : own;
  endfunction

  function automatic logic [TIME_W-1:0] sat_time(input logic [31:0] v);
    sat_time = (v > 32'(TIME_MAX_TICKS)) ? TIME_W'(TIME_MAX_TICKS) : v[TIME_W-1:0];
  endfunction

  // Word index of a register within a five-entry table
  function automatic logic [2:0] slot_index(input logic [7:0] a, input logic [7:0] base);
    slot_index = 3'((a - base) >> 2);
  endfunction

  function automatic force_t to_force(input logic [1:0] v);
    to_force = (v == 2'b11) ? FORCE_NORMAL : force_t'(v);
  endfunction

  generate
    for (genvar i = 0; i < NUM_RELAYS; i++) begin : g_relay
      assign force_eff[i] = merge_force(group_force, force_sel[i]);
      relay_channel u_ch (
        .clk            (clk),
        .rst_n          (rst_n),
        .tick           (tick),
        .drive          (drive_s[i]),
        .ack            (ack_eff[i]),
        .latch_en       (latch_en[i]),
        .closed_circuit (closed_circuit[i]),
        .force_sel      (force_eff[i]),
        .hold_time      (hold_time[i]),
        .off_delay      (off_delay[i]),
        .active         (active[i]),
        .latched        (latched[i]),
        .coil           (coil_int[i])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_coil <= '0;
    end else begin
      relay_coil <= coil_int;
    end
  end

  // Write channel: address and data taken in either order
  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_GROUP) ||
                  (aw_addr == ADDR_ACK) ||
                  (aw_addr >= ADDR_HOLD0 && aw_addr < ADDR_HOLD0 + 8'h14) ||
                  (aw_addr >= ADDR_OFFD0 && aw_addr < ADDR_OFFD0 + 8'h14);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (!aw_held && s_axi_awvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (!w_held && s_axi_wvalid && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings registers; full-word writes expected, strobe lane 0 gates all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      group_force    <= FORCE_NORMAL;
      latch_en       <= LATCH_RESET;
      closed_circuit <= CCP_RESET;
      remote_ack     <= 1'b0;
      for (int i = 0; i < NUM_RELAYS; i++) begin
        force_sel[i] <= FORCE_NORMAL;
        hold_time[i] <= HOLD_RESET;
        off_delay[i] <= OFFD_RESET;
      end
    end else begin
      remote_ack <= 1'b0;
      if (wr_go && w_strb[0]) begin
        if (aw_addr == ADDR_CTRL) begin
          for (int i = 0; i < NUM_RELAYS; i++) begin
            force_sel[i] <= to_force(w_data[CTRL_FORCE_LSB + 2*i +: 2]);
          end
          latch_en       <= w_data[CTRL_LATCH_LSB +: NUM_RELAYS];
          closed_circuit <= w_data[CTRL_CCP_LSB +: NUM_RELAYS];
        end
        if (aw_addr == ADDR_GROUP) begin
          group_force <= to_force(w_data[1:0]);
        end
        if (aw_addr == ADDR_ACK) begin
          remote_ack <= w_data[0];
        end
        for (int i = 0; i < NUM_RELAYS; i++) begin
          if (aw_addr == ADDR_HOLD0 + 8'(4*i)) begin
            hold_time[i] <= sat_time(w_data);
          end
          if (aw_addr == ADDR_OFFD0 + 8'(4*i)) begin
            off_delay[i] <= sat_time(w_data);
          end
        end
      end
    end
  end

  // Read channel, one cycle to rvalid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= '0;
        unique case ({s_axi_araddr[7:2], 2'b00})
          ADDR_CTRL: begin
            for (int i = 0; i < NUM_RELAYS; i++) begin
              s_axi_rdata[CTRL_FORCE_LSB + 2*i +: 2] <= force_sel[i];
            end
            s_axi_rdata[CTRL_LATCH_LSB +: NUM_RELAYS] <= latch_en;
            s_axi_rdata[CTRL_CCP_LSB +: NUM_RELAYS]   <= closed_circuit;
          end
          ADDR_GROUP:  s_axi_rdata[1:0] <= group_force;
          ADDR_STATUS: s_axi_rdata <= {17'h0, latched, active, coil_int};
          ADDR_ACK:    s_axi_rdata <= '0;
          default: begin
            if (s_axi_araddr >= ADDR_HOLD0 && s_axi_araddr < ADDR_HOLD0 + 8'h14) begin
              s_axi_rdata[TIME_W-1:0] <= hold_time[slot_index(s_axi_araddr, ADDR_HOLD0)];
            end else if (s_axi_araddr >= ADDR_OFFD0 && s_axi_araddr < ADDR_OFFD0 + 8'h14) begin
              s_axi_rdata[TIME_W-1:0] <= off_delay[slot_index(s_axi_araddr, ADDR_OFFD0)];
            end else begin
              s_axi_rresp <= RESP_SLVERR;
            end
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_group_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (group_force != FORCE_NORMAL) |-> (force_eff[0] == group_force))
    else $error("group force did not override relay force");
  a_remote_ack: assert property (@(posedge clk) disable iff (!rst_n)
    (remote_ack && latched[0] && latch_en[0] && !drive_s[0] &&
     g_relay[0].u_ch.hold_cnt == '0) |=> !latched[0])
    else $error("common ack did not clear a releasable latch");
  a_group_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (group_force == FORCE_ENERGIZED) [*3] |-> (relay_coil == '1))
    else $error("group energized force did not reach all coils");
endmodule

// ---- relay_cond_pkg.sv ----
// Purpose: Shared constants for the relay output conditioner
// Assumes: 200 MHz clock, AXI4-Lite register access
// Notes:   Times are held in units of 10 ms
package relay_cond_pkg;

  localparam int NUM_RELAYS = 5;
  localparam int CLK_HZ     = 200_000_000;
  localparam int TICK_MS    = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TIME_MAX_TICKS = 30000;
  localparam int TIME_W     = 15;
  localparam logic [TIME_W-1:0] HOLD_RESET = 15'h0000;
  localparam logic [TIME_W-1:0] OFFD_RESET = 15'h0000;

  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'b00,
    FORCE_DEENERGIZED = 2'b01,
    FORCE_ENERGIZED = 2'b10
  } force_t;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_GROUP  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ACK    = 8'h0c;
  localparam logic [7:0] ADDR_HOLD0  = 8'h10;
  localparam logic [7:0] ADDR_OFFD0  = 8'h30;

  localparam int CTRL_FORCE_LSB = 0;
  localparam int CTRL_LATCH_LSB = 16;
  localparam int CTRL_CCP_LSB   = 24;
  localparam logic [NUM_RELAYS-1:0] LATCH_RESET = 5'h1f;
  localparam logic [NUM_RELAYS-1:0] CCP_RESET   = 5'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- relay_sync.sv ----
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   Output changes when stages two and three agree
`timescale 1ns/1ps
module relay_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule

// ---- relay_channel.sv ----
// Purpose: One relay channel: latch, ack, off delay, hold, force
// Assumes: tick pulses once per 10 ms
// Notes:   Coil output is registered
`timescale 1ns/1ps
module relay_channel
  import relay_cond_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire logic              drive,
  input  wire logic              ack,
  input  wire logic              latch_en,
  input  wire logic              closed_circuit,
  input  wire force_t            force_sel,
  input  wire logic [TIME_W-1:0] hold_time,
  input  wire logic [TIME_W-1:0] off_delay,
  output logic                   active,
  output logic                   latched,
  output logic                   coil
);
  logic [TIME_W-1:0] hold_cnt;
  logic [TIME_W-1:0] off_cnt;
  logic              want;
  logic              next_coil;

  // Latch holds pickup; ack only once drive gone and hold expired
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= 1'b0;
    end else if (drive && latch_en) begin
      latched <= 1'b1;
    end else if (ack && latch_en && !drive && hold_cnt == '0) begin
      latched <= 1'b0;
    end
  end

  // Switch-off delay stretches the release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt <= '0;
    end else if (drive || latched) begin
      off_cnt <= off_delay;
    end else if (tick && off_cnt != '0) begin
      off_cnt <= off_cnt - 1'b1;
    end
  end

  assign want = drive || latched || off_cnt != '0;

  always_comb begin
    unique case (force_sel)
      FORCE_ENERGIZED:   next_coil = 1'b1;
      FORCE_DEENERGIZED: next_coil = 1'b0;
      default:           next_coil = want ^ closed_circuit;
    endcase
  end

  // Hold time applies to normal operation only; forcing overrides it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coil     <= 1'b0;
      active   <= 1'b0;
      hold_cnt <= '0;
    end else begin
      active <= want;
      if (next_coil != coil && (hold_cnt == '0 || force_sel != FORCE_NORMAL)) begin
        coil     <= next_coil;
        hold_cnt <= hold_time;
      end else if (tick && hold_cnt != '0) begin
        hold_cnt <= hold_cnt - 1'b1;
      end
    end
  end

  a_hold_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (hold_cnt != '0 && force_sel == FORCE_NORMAL) |=> $stable(coil))
    else $error("coil changed during hold time");
  a_force_on: assert property (@(posedge clk) disable iff (!rst_n)
    force_sel == FORCE_ENERGIZED [*2] |-> coil)
    else $error("forced energized relay is off");
  a_force_off: assert property (@(posedge clk) disable iff (!rst_n)
    force_sel == FORCE_DEENERGIZED [*2] |-> !coil)
    else $error("forced de-energized relay is on");
  a_latch_set: assert property (@(posedge clk) disable iff (!rst_n)
    (drive && latch_en) |=> latched)
    else $error("latch failed to set");
  a_ack_early: assert property (@(posedge clk) disable iff (!rst_n)
    (latched && (drive || hold_cnt != '0)) |=> latched)
    else $error("latch cleared too early");
  a_ack_unlatched: assert property (@(posedge clk) disable iff (!rst_n)
    (latched && !latch_en) |=> latched)
    else $error("ack acted with latch disabled");
endmodule

// ---- relay_coil_bank.sv ----
// Purpose: Behavioural bank of relay coils at the conditioner outputs
// Assumes: Armature follows its coil one clock later
// Notes:   Contact is what the field wiring would see
`timescale 1ns/1ps
module relay_coil_bank (
  input  wire logic       clk,
  input  wire logic [4:0] coil,
  output logic      [4:0] contact
);
  // Mechanical lag kept to one cycle so checks stay short
  always_ff @(posedge clk) begin
    contact <= coil;
  end
endmodule

// ---- relay_output_conditioner_tb.sv ----
// Purpose: Self-checking bench for the relay output conditioner
// Assumes: TICK_DIV of 10, so one time unit is 10 cycles
// Notes:   Pin changes need about 6 cycles; checks wait 12
`timescale 1ns/1ps
module relay_output_conditioner_tb;
  import relay_cond_pkg::*;
  logic        clk = 0;
  logic        rstn = 0;
  logic [4:0]  drv = 0;
  logic [4:0]  ack = 0;
  logic        ext_ack = 0;
  logic [7:0]  awaddr = 0;
  logic        awvalid = 0;
  logic        awready;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 0;
  logic        wvalid = 0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 0;
  logic [7:0]  araddr = 0;
  logic        arvalid = 0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 0;
  logic [4:0]  coil;
  logic [4:0]  contact;
  int          errors = 0;
  int          checks = 0;

  always #2.5 clk = ~clk;

  relay_output_conditioner #(.TICK_DIV(10)) dut (
    .clk(clk), .rstn(rstn), .relay_drive(drv), .relay_ack(ack),
    .ext_ack(ext_ack), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .relay_coil(coil)
  );

  relay_coil_bank coils (.clk(clk), .coil(coil), .contact(contact));

  task automatic complete_run;
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w, done;
    aw = 1;
    w = 1;
    done = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    repeat (50) if (!done) begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready === 1'b1) begin
        w = 0;
        wvalid <= 0;
      end
      if (bvalid === 1'b1) begin
        done = 1;
        bready <= 0;
        chk("bresp", bresp, er);
      end
    end
    if (!done) chk("bvalid", 0, 1);
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, done;
    ar = 1;
    done = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    repeat (50) if (!done) begin
      @(posedge clk);
      if (ar && arready === 1'b1) begin
        ar = 0;
        arvalid <= 0;
      end
      if (rvalid === 1'b1) begin
        done = 1;
        rready <= 0;
        chk("rresp", rresp, er);
        if (er == RESP_OKAY) chk("rdata", rdata, ed);
      end
    end
    if (!done) chk("rvalid", 0, 1);
    @(posedge clk);
  endtask

  task automatic t_reset;
    chk("coil", coil, 0);
    rd(ADDR_CTRL, 32'h001f0000, RESP_OKAY);
    rd(ADDR_GROUP, 0, RESP_OKAY);
    rd(ADDR_HOLD0, 0, RESP_OKAY);
    rd(ADDR_OFFD0, 0, RESP_OKAY);
    wr(ADDR_HOLD0 + 8'h10, 32'h00009c40, 4'hf, RESP_OKAY);
    rd(ADDR_HOLD0 + 8'h10, 32'(TIME_MAX_TICKS), RESP_OKAY);
    wr(ADDR_HOLD0 + 8'h10, 0, 4'hf, RESP_OKAY);
    wr(ADDR_GROUP, 32'h00000003, 4'hf, RESP_OKAY);
    rd(ADDR_GROUP, 0, RESP_OKAY);
    wr(ADDR_CTRL, 0, 4'h0, RESP_OKAY);
    rd(ADDR_CTRL, 32'h001f0000, RESP_OKAY);
    wr(8'h50, 1, 4'hf, RESP_SLVERR);
    rd(8'h50, 0, RESP_SLVERR);
  endtask

  // Early acks fall while drive is gone but hold still runs
  task automatic t_latch;
    wr(ADDR_HOLD0, 32'd20, 4'hf, RESP_OKAY);
    rd(ADDR_HOLD0, 32'h00000014, RESP_OKAY);
    drv[0] <= 1;
    wait_n(12);
    chk("coil0", coil[0], 1);
    drv[0] <= 0;
    ack[0] <= 1;
    wait_n(30);
    ack[0] <= 0;
    chk("coil0 early ack", coil[0], 1);
    ack[1] <= 1;
    wait_n(12);
    ack[1] <= 0;
    chk("coil0 other ack", coil[0], 1);
    wait_n(250);
    ack[0] <= 1;
    wait_n(12);
    ack[0] <= 0;
    chk("coil0 acked", coil[0], 0);
    wr(ADDR_HOLD0, 0, 4'hf, RESP_OKAY);
  endtask

  // Relay 1 is latched, then loses its latch option before ack is held
  task automatic t_nolatch;
    drv[1] <= 1;
    wait_n(12);
    drv[1] <= 0;
    wait_n(12);
    chk("coil1 latched", coil[1], 1);
    wr(ADDR_CTRL, 32'h00190000, 4'hf, RESP_OKAY);
    wr(ADDR_HOLD0 + 8'h08, 32'd10, 4'hf, RESP_OKAY);
    drv[2] <= 1;
    ack[2] <= 1;
    ack[1] <= 1;
    wait_n(3);
    drv[2] <= 0;
    wait_n(12);
    chk("coil2 held", coil[2], 1);
    wait_n(150);
    ack[2] <= 0;
    chk("coil2 released", coil[2], 0);
    chk("coil1 ack ignored", coil[1], 1);
    wr(ADDR_CTRL, 32'h001b0000, 4'hf, RESP_OKAY);
    wait_n(12);
    ack[1] <= 0;
    chk("coil1 acked", coil[1], 0);
    wr(ADDR_CTRL, 32'h00190000, 4'hf, RESP_OKAY);
  endtask

  task automatic t_principle;
    wr(ADDR_OFFD0 + 8'h04, 32'd10, 4'hf, RESP_OKAY);
    rd(ADDR_OFFD0 + 8'h04, 32'h0000000a, RESP_OKAY);
    drv[1] <= 1;
    wait_n(12);
    chk("coil1", coil[1], 1);
    drv[1] <= 0;
    wait_n(50);
    chk("coil1 delayed", coil[1], 1);
    wait_n(100);
    chk("coil1 off", coil[1], 0);
    wr(ADDR_CTRL, 32'h10090000, 4'hf, RESP_OKAY);
    wait_n(12);
    chk("coil4 rest", coil[4], 1);
    drv[4] <= 1;
    wait_n(12);
    chk("coil4 active", coil[4], 0);
    drv[4] <= 0;
    wait_n(12);
    chk("coil4 back", coil[4], 1);
  endtask

  task automatic t_force;
    wr(ADDR_CTRL, 32'h10090000 | (32'(FORCE_ENERGIZED) << 6), 4'hf, RESP_OKAY);
    wait_n(12);
    chk("coil forced on", coil, 5'h18);
    drv[3] <= 1;
    wr(ADDR_CTRL, 32'h10090000 | (32'(FORCE_DEENERGIZED) << 6), 4'hf, RESP_OKAY);
    wait_n(12);
    chk("coil forced off", coil, 5'h10);
    wr(ADDR_GROUP, 32'(FORCE_ENERGIZED), 4'hf, RESP_OKAY);
    wait_n(12);
    chk("coil group on", coil, 5'h1f);
    wr(ADDR_GROUP, 32'(FORCE_DEENERGIZED), 4'hf, RESP_OKAY);
    wait_n(12);
    chk("coil group off", coil, 5'h00);
    wr(ADDR_GROUP, 0, 4'hf, RESP_OKAY);
    wr(ADDR_CTRL, 32'h10090000, 4'hf, RESP_OKAY);
    wait_n(12);
    drv[3] <= 0;
    wait_n(12);
    chk("coil normal", coil, 5'h18);
  endtask

  task automatic t_common_ack;
    drv[0] <= 1;
    wait_n(12);
    drv[0] <= 0;
    wait_n(12);
    chk("coil latched", coil, 5'h19);
    rd(ADDR_STATUS, 32'h00002539, RESP_OKAY);
    ext_ack <= 1;
    wait_n(12);
    ext_ack <= 0;
    chk("coil ext ack", coil, 5'h10);
    drv[0] <= 1;
    wait_n(12);
    drv[0] <= 0;
    wait_n(12);
    wr(ADDR_ACK, 1, 4'hf, RESP_OKAY);
    wait_n(12);
    chk("coil remote ack", coil, 5'h10);
    chk("contact", contact, 5'h10);
    rd(ADDR_STATUS, 32'h00000010, RESP_OKAY);
  endtask

  initial begin
    wait_n(16);
    rstn <= 1;
    wait_n(6);
    t_reset();
    t_latch();
    t_nolatch();
    t_principle();
    t_force();
    t_common_ack();
    complete_run();
  end

  initial begin
    #(5 * 20000);
    errors++;
    complete_run();
  end
endmodule
